// *** burst_sram_access.sv ***
// pipelined burst sram access logic: input/output registers, burst counter, byte writes, output control
//
// Operation
// - register all synchronous inputs on rising edge
// - read data leaves through output register
// - burst order chosen by static strap
// - two-bit counter loads start, generates rest
// - low advance steps the burst counter
// - strap high: interleaved order, start xor step
// - strobe plus chip selects, no write: read
// - read data driven after next edge
// - first cycle from deselect stays three-stated
// - afterwards output enable gates drivers after a read cycle, except in write or deselect cycles
// - back-to-back reads; deselect floats at once
// - processor-strobe write: address first, two clocks
// - second clock: global or byte-lane write
// - global write writes all four lanes
// - byte write only touches selected lanes
// - drivers float whenever write cycle detected
// - controller-strobe write completes in one clock
// - bursts continue for reads and writes
// - strap low: linear order, modulo four
// - both strobes low with first chip select low: processor strobe wins
// - processor-strobe access always starts as read
`timescale 1ns/1ps

module burst_sram_access
   import burst_sram_pkg::*;
(
   // system side
   input  wire logic              clock,
   input  wire logic              sys_rst,
   output logic                   read_done,
   output logic                   write_done,
   // sram bus clock and static strap
   input  wire logic              sram_clk,
   input  wire logic              burst_order_strap,
   // address and controls
   input  wire logic [ADDR_W-1:0] addr,
   input  wire logic              proc_addr_strobe_n,
   input  wire logic              ctrl_addr_strobe_n,
   input  wire logic              burst_advance_n,
   input  wire logic              chip_sel_first_n,
   input  wire logic              chip_sel_second,
   input  wire logic              chip_sel_third_n,
   input  wire logic              global_write_n,
   input  wire logic              byte_write_enable_n,
   input  wire logic [LANES-1:0]  byte_lane_select_n,
   input  wire logic              out_enable_n,
   // data and parity lines
   input  wire logic [DATA_W-1:0] dq_in,
   output logic      [DATA_W-1:0] dq_out,
   output logic                   dq_oe,
   input  wire logic [PAR_W-1:0]  parity_lines_in,
   output logic      [PAR_W-1:0]  parity_lines_out,
   output logic                   parity_lines_oe
);

   // =====================================================
   // functions
   function automatic logic [CNT_W-1:0] burst_addr(input logic [CNT_W-1:0] start,
                                                   input logic [CNT_W-1:0] step,
                                                   input logic             linear);
      burst_addr = linear ? CNT_W'(start + step) : (start ^ step);
   endfunction

   function automatic logic [WORD_W-1:0] merge_lanes(input logic [WORD_W-1:0] old_w,
                                                     input logic [WORD_W-1:0] new_w,
                                                     input logic [LANES-1:0]  mask);
      logic [WORD_W-1:0] res;
      res = old_w;
      for (int i = 0; i < LANES; i++) begin
         if (mask[i]) begin
            res[i*LANE_BITS +: LANE_BITS] = new_w[i*LANE_BITS +: LANE_BITS];
            res[DATA_W+i]                 = new_w[DATA_W+i];
         end
      end
      merge_lanes = res;
   endfunction

   // =====================================================
   // link-domain reset and strap synchronisers
   logic rst_meta_ff, link_rst_ff, strap_meta_ff, strap_ff;

   always_ff @(posedge sram_clk) begin
      rst_meta_ff <= sys_rst;
      link_rst_ff <= rst_meta_ff;
   end

   // strap is static, so a plain level synchroniser is enough
   always_ff @(posedge sram_clk) begin
      strap_meta_ff <= burst_order_strap;
      strap_ff      <= strap_meta_ff;
   end

   logic linear;
   assign linear = ~strap_ff;

   // =====================================================
   // input registers
   logic [ADDR_W-1:0] addr_ff;
   logic [WORD_W-1:0] wdata_ff;
   logic              proc_addr_strobe_n_n_ff, ctrl_addr_strobe_n_n_ff, adv_n_ff, ce1_n_ff, ce2_ff, ce3_n_ff, gw_n_ff, bwe_n_ff;
   logic [LANES-1:0]  bw_n_ff;

   always_ff @(posedge sram_clk) begin
      if (link_rst_ff) begin
         addr_ff   <= ADDR_RST;
         wdata_ff  <= WORD_RST;
         proc_addr_strobe_n_n_ff <= 1'b1;
         ctrl_addr_strobe_n_n_ff <= 1'b1;
         adv_n_ff  <= 1'b1;
         ce1_n_ff  <= 1'b1;
         ce2_ff    <= 1'b0;
         ce3_n_ff  <= 1'b1;
         gw_n_ff   <= 1'b1;
         bwe_n_ff  <= 1'b1;
         bw_n_ff   <= BWSEL_RST;
      end else begin
         addr_ff   <= addr;
         wdata_ff  <= {parity_lines_in, dq_in};
         proc_addr_strobe_n_n_ff <= proc_addr_strobe_n;
         ctrl_addr_strobe_n_n_ff <= ctrl_addr_strobe_n;
         adv_n_ff  <= burst_advance_n;
         ce1_n_ff  <= chip_sel_first_n;
         ce2_ff    <= chip_sel_second;
         ce3_n_ff  <= chip_sel_third_n;
         gw_n_ff   <= global_write_n;
         bwe_n_ff  <= byte_write_enable_n;
         bw_n_ff   <= byte_lane_select_n;
      end
   end

   // =====================================================
   // cycle decode
   acc_state_e        state_ff;
   logic [ADDR_W-1:0] hi_ff;
   logic [CNT_W-1:0]  start_ff, step_ff;
   logic              ce_ok, proc_addr_strobe_n_act, ctrl_addr_strobe_n_act, strobe, start_now, desel_now, write_req;
   logic              cont, wr_now, rd_now;
   logic [CNT_W-1:0]  nxt_step;
   logic [ADDR_W-1:0] acc_addr;
   logic [LANES-1:0]  lane_mask;

   assign ce_ok     = ~ce1_n_ff & ce2_ff & ~ce3_n_ff;
   assign proc_addr_strobe_n_act  = ~proc_addr_strobe_n_n_ff & ~ce1_n_ff;
   assign ctrl_addr_strobe_n_act  = ~ctrl_addr_strobe_n_n_ff & ~proc_addr_strobe_n_act;
   assign strobe    = proc_addr_strobe_n_act | ctrl_addr_strobe_n_act;
   assign start_now = strobe & ce_ok;
   assign desel_now = strobe & ~ce_ok;
   assign write_req = ~gw_n_ff | (~bwe_n_ff & ~(&bw_n_ff));
   assign cont      = ~strobe & (state_ff == ST_ACTIVE);

   // a processor-strobe start is always a read; its write lands on the next clock
   assign wr_now = (start_now & ctrl_addr_strobe_n_act & write_req) | (cont & write_req);
   assign rd_now = (start_now & ~wr_now) | (cont & ~write_req);

   // advance is only honoured on continuation cycles, never on the address cycle
   assign nxt_step = (cont & ~adv_n_ff) ? CNT_W'(step_ff + CNT_ONE) : step_ff;

   always_comb begin
      if (start_now) begin
         acc_addr = addr_ff;
      end else begin
         acc_addr = {hi_ff[ADDR_W-1:CNT_W], burst_addr(start_ff, nxt_step, linear)};
      end
   end

   always_comb begin
      if (!gw_n_ff) begin
         lane_mask = LANE_ALL;
      end else if (!bwe_n_ff) begin
         lane_mask = ~bw_n_ff;
      end else begin
         lane_mask = LANE_NONE;
      end
   end

   // =====================================================
   // access state and burst counter
   always_ff @(posedge sram_clk) begin
      if (link_rst_ff) begin
         state_ff <= ST_DESEL;
      end else begin
         case (state_ff)
            ST_DESEL:  state_ff <= start_now ? ST_ACTIVE : ST_DESEL;
            ST_ACTIVE: state_ff <= desel_now ? ST_DESEL : ST_ACTIVE;
            default:   state_ff <= ST_DESEL;
         endcase
      end
   end

   always_ff @(posedge sram_clk) begin
      if (link_rst_ff) begin
         hi_ff    <= ADDR_RST;
         start_ff <= CNT_RST;
         step_ff  <= CNT_RST;
      end else if (start_now) begin
         hi_ff    <= addr_ff;
         start_ff <= addr_ff[CNT_W-1:0];
         step_ff  <= CNT_RST;
      end else if (cont) begin
         step_ff  <= nxt_step;
      end
   end

   // =====================================================
   // array, output register and drivers
   logic [WORD_W-1:0] mem_ff [DEPTH];
   logic [WORD_W-1:0] rd_word, rdata_ff;
   logic              drive_ff;

   assign rd_word = mem_ff[acc_addr];

   always_ff @(posedge sram_clk) begin
      if (wr_now) begin
         mem_ff[acc_addr] <= merge_lanes(mem_ff[acc_addr], wdata_ff, lane_mask);
      end
   end

   always_ff @(posedge sram_clk) begin
      if (link_rst_ff) begin
         rdata_ff <= WORD_RST;
      end else if (rd_now) begin
         rdata_ff <= rd_word;
      end
   end

   // drive_ff is low through the cycle a start is decoded from deselect, so OE is masked there
   always_ff @(posedge sram_clk) begin
      if (link_rst_ff) begin
         drive_ff <= 1'b0;
      end else begin
         drive_ff <= rd_now;
      end
   end

   // out_enable_n is asynchronous by nature and gates the drivers without sampling
   assign dq_oe            = drive_ff & ~out_enable_n & ~wr_now & ~desel_now;
   assign parity_lines_oe  = dq_oe;
   assign dq_out           = rdata_ff[DATA_W-1:0];
   assign parity_lines_out = rdata_ff[WORD_W-1:DATA_W];

   // =====================================================
   // event crossing into the system clock
   logic rd_tgl_ff, wr_tgl_ff;

   always_ff @(posedge sram_clk) begin
      if (link_rst_ff) begin
         rd_tgl_ff <= 1'b0;
         wr_tgl_ff <= 1'b0;
      end else begin
         rd_tgl_ff <= rd_tgl_ff ^ rd_now;
         wr_tgl_ff <= wr_tgl_ff ^ wr_now;
      end
   end

   logic [2:0] rd_sync_ff, wr_sync_ff;

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         rd_sync_ff <= 3'h0;
         wr_sync_ff <= 3'h0;
      end else begin
         rd_sync_ff <= {rd_sync_ff[1:0], rd_tgl_ff};
         wr_sync_ff <= {wr_sync_ff[1:0], wr_tgl_ff};
      end
   end

   // stage 0 feeds only stage 1; edges are taken between stages 1 and 2
   assign read_done  = rd_sync_ff[2] ^ rd_sync_ff[1];
   assign write_done = wr_sync_ff[2] ^ wr_sync_ff[1];

   // =====================================================
   // checks
   chk_input_capture: assert property (@(posedge sram_clk) disable iff (link_rst_ff)
      ##1 (addr_ff == $past(addr) && bw_n_ff == $past(byte_lane_select_n))) else $error("inputs not registered");
   chk_read_pipe: assert property (@(posedge sram_clk) disable iff (link_rst_ff)
      rd_now |=> (rdata_ff == $past(rd_word) && drive_ff)) else $error("read data not in output register");
   chk_interleave_seq: assert property (@(posedge sram_clk) disable iff (link_rst_ff)
      (cont && !linear) |-> acc_addr[1:0] == (start_ff ^ nxt_step)) else $error("interleaved address wrong");
   chk_linear_seq: assert property (@(posedge sram_clk) disable iff (link_rst_ff)
      (cont && linear) |-> acc_addr[1:0] == CNT_W'(start_ff + nxt_step)) else $error("linear address wrong");
   chk_advance_step: assert property (@(posedge sram_clk) disable iff (link_rst_ff)
      (cont && !adv_n_ff) |=> step_ff == CNT_W'($past(step_ff) + CNT_ONE)) else $error("advance did not step");
   chk_first_float: assert property (@(posedge sram_clk) disable iff (link_rst_ff)
      (start_now && state_ff == ST_DESEL) |-> !dq_oe) else $error("drove in first cycle");
   chk_deselect_float: assert property (@(posedge sram_clk) disable iff (link_rst_ff)
      desel_now |-> !dq_oe ##1 (state_ff == ST_DESEL && !drive_ff)) else $error("deselect did not float");
   chk_write_float: assert property (@(posedge sram_clk) disable iff (link_rst_ff)
      wr_now |-> !dq_oe && !parity_lines_oe) else $error("drove during write");
   chk_proc_addr_strobe_n_read: assert property (@(posedge sram_clk) disable iff (link_rst_ff)
      (start_now && proc_addr_strobe_n_act) |-> (rd_now && !wr_now)) else $error("processor strobe started a write");
   chk_global_lanes: assert property (@(posedge sram_clk) disable iff (link_rst_ff)
      (wr_now && !gw_n_ff) |-> lane_mask == LANE_ALL) else $error("global write missed a lane");
   chk_byte_lanes: assert property (@(posedge sram_clk) disable iff (link_rst_ff)
      (wr_now && gw_n_ff) |-> lane_mask == ~bw_n_ff) else $error("byte write lane mismatch");
   chk_oe_alone: assert property (@(posedge sram_clk) disable iff (link_rst_ff)
      (drive_ff && !wr_now && !desel_now) |-> dq_oe == !out_enable_n) else $error("output enable ignored");

endmodule

// *** burst_sram_pkg.sv ***
// shared constants for the pipelined burst sram access block
package burst_sram_pkg;

   // =====================================================
   // array geometry
   localparam int ADDR_W    = 16;
   localparam int DEPTH     = 65536;
   localparam int DATA_W    = 32;
   localparam int PAR_W     = 4;
   localparam int LANES     = 4;
   localparam int LANE_BITS = 8;
   localparam int WORD_W    = DATA_W + PAR_W;
   localparam int CNT_W     = 2;

   // =====================================================
   // reset values, lane masks and counter step
   localparam logic [CNT_W-1:0]  CNT_RST   = 2'h0;
   localparam logic [WORD_W-1:0] WORD_RST  = 36'h0;
   localparam logic [ADDR_W-1:0] ADDR_RST  = 16'h0;
   localparam logic [LANES-1:0]  LANE_NONE = 4'h0;
   localparam logic [LANES-1:0]  LANE_ALL  = 4'hF;
   localparam logic [LANES-1:0]  BWSEL_RST = 4'hF;
   localparam logic [CNT_W-1:0]  CNT_ONE   = 2'h1;

   // =====================================================
   // access state
   typedef enum logic {ST_DESEL, ST_ACTIVE} acc_state_e;

endpackage

// *** host_model.sv ***
// bus-side model of the cache controller that drives the sram pins
`timescale 1ns/1ps

module host_model
   import burst_sram_pkg::*;
(
   // link clock
   input  wire logic              sram_clk,
   // address and controls
   output logic      [ADDR_W-1:0] addr,
   output logic                   proc_addr_strobe_n,
   output logic                   ctrl_addr_strobe_n,
   output logic                   burst_advance_n,
   output logic                   chip_sel_first_n,
   output logic                   chip_sel_second,
   output logic                   chip_sel_third_n,
   output logic                   global_write_n,
   output logic                   byte_write_enable_n,
   output logic      [LANES-1:0]  byte_lane_select_n,
   output logic                   out_enable_n,
   // write data
   output logic      [DATA_W-1:0] dq_in,
   output logic      [PAR_W-1:0]  parity_lines_in
);
   // =====================================================
   // idle pins: unselected, no strobes
   initial begin
      {proc_addr_strobe_n, ctrl_addr_strobe_n, burst_advance_n, chip_sel_first_n} = 4'hF;
      {chip_sel_second, chip_sel_third_n, global_write_n, byte_write_enable_n} = 4'h7;
      byte_lane_select_n = 4'hF;
      out_enable_n = 1'h1;
      addr = ADDR_RST;
      {parity_lines_in, dq_in} = WORD_RST;
   end

   // =====================================================
   // one bus cycle: pins change after the edge and hold a full period
   task automatic drive(input logic [2:0] ctl, input logic [1:0] sel, input logic [5:0] wr,
                        input logic oe_n, input logic [ADDR_W-1:0] a, input logic [WORD_W-1:0] d);
      @(posedge sram_clk);
      {proc_addr_strobe_n, ctrl_addr_strobe_n, burst_advance_n} <= ctl;
      {chip_sel_first_n, chip_sel_second} <= sel;
      chip_sel_third_n <= 1'h0;
      {global_write_n, byte_write_enable_n, byte_lane_select_n} <= wr;
      out_enable_n <= oe_n;
      addr <= a;
      // released data lines flip so a stale value never matches by luck
      if (wr == 6'h3F)
         {parity_lines_in, dq_in} <= ~{parity_lines_in, dq_in};
      else
         {parity_lines_in, dq_in} <= d;
   endtask
endmodule

// *** tb_pipelined_burst_sram_access.sv ***
// self-checking bench for the pipelined burst sram access block
`timescale 1ns/1ps
`define CHK(g, e, m) begin samples_checked++; if ((g) !== (e)) begin num_errors++; $display("mismatch at %0t: %s", $time, m); end end

module tb_pipelined_burst_sram_access
   import burst_sram_pkg::*;
;
   logic                   clock, sys_rst, sram_clk, burst_order_strap, read_done, write_done;
   logic      [ADDR_W-1:0] addr;
   logic                   proc_addr_strobe_n, ctrl_addr_strobe_n, burst_advance_n, out_enable_n;
   logic                   chip_sel_first_n, chip_sel_second, chip_sel_third_n;
   logic                   global_write_n, byte_write_enable_n, dq_oe, parity_lines_oe;
   logic      [LANES-1:0]  byte_lane_select_n;
   logic      [DATA_W-1:0] dq_in, dq_out;
   logic      [PAR_W-1:0]  parity_lines_in, parity_lines_out;
   logic      [WORD_W-1:0] word;
   int                     num_errors = 0;
   int                     samples_checked = 0;
   int                     wr_events = 0;
   int                     rd_events = 0;

   assign word = {parity_lines_out, dq_out};

   burst_sram_access i_burst_sram_access (
      .clock, .sys_rst, .read_done, .write_done, .sram_clk, .burst_order_strap, .addr,
      .proc_addr_strobe_n, .ctrl_addr_strobe_n, .burst_advance_n, .chip_sel_first_n, .chip_sel_second,
      .chip_sel_third_n, .global_write_n, .byte_write_enable_n, .byte_lane_select_n, .out_enable_n,
      .dq_in, .dq_out, .dq_oe, .parity_lines_in, .parity_lines_out, .parity_lines_oe);

   host_model i_host_model (
      .sram_clk, .addr, .proc_addr_strobe_n, .ctrl_addr_strobe_n, .burst_advance_n, .chip_sel_first_n,
      .chip_sel_second, .chip_sel_third_n, .global_write_n, .byte_write_enable_n, .byte_lane_select_n,
      .out_enable_n, .dq_in, .parity_lines_in);

   // =====================================================
   // clocks, event counters, watchdog
   initial begin
      clock = 1'h0;
      forever #20 clock = ~clock;
   end
   initial begin
      sram_clk = 1'h0;
      #1.7;
      forever #3 sram_clk = ~sram_clk;
   end
   always @(posedge clock) begin
      if (write_done === 1'h1) wr_events++;
      if (read_done === 1'h1) rd_events++;
   end
   initial begin
      #100us;
      num_errors++;
      complete_run();
   end

   // =====================================================
   // bus cycles
   task automatic rd(input logic [ADDR_W-1:0] a, input logic p);
      i_host_model.drive({~p, p, 1'h1}, 2'h1, 6'h3F, 1'h0, a, WORD_RST);
   endtask
   task automatic wr(input logic [2:0] c, input logic [5:0] w, input logic [ADDR_W-1:0] a, input logic [WORD_W-1:0] d);
      i_host_model.drive(c, 2'h1, w, 1'h1, a, d);
   endtask
   task automatic nx(input logic adv_n, input logic oe_n);
      i_host_model.drive({2'h3, adv_n}, 2'h1, 6'h3F, oe_n, ADDR_RST, WORD_RST);
      #1;
   endtask
   task automatic desel();
      i_host_model.drive(3'h5, 2'h0, 6'h3F, 1'h0, ADDR_RST, WORD_RST);
   endtask
   task automatic rdchk(input logic [ADDR_W-1:0] a, input logic p, input logic [WORD_W-1:0] e);
      desel();
      rd(a, p);
      nx(1'h1, 1'h0);
      `CHK(dq_oe, 1'h0, "driving in first cycle")
      nx(1'h1, 1'h0);
      `CHK(word, e, "read word")
      `CHK(dq_oe, 1'h1, "not driving after first cycle")
      `CHK(parity_lines_oe, 1'h1, "parity lines not driving")
   endtask

   // =====================================================
   // scenarios
   task automatic s_global();
      wr(3'h5, 6'h1F, 16'h0010, 36'hC_1234_5678);
      wr(3'h5, 6'h1F, 16'h0011, 36'h3_8765_4321);
      rdchk(16'h0010, 1'h0, 36'hC_1234_5678);
      rd(16'h0011, 1'h1);
      nx(1'h1, 1'h0);
      `CHK(dq_oe, 1'h1, "drivers dropped between reads")
      nx(1'h1, 1'h1);
      `CHK(dq_oe, 1'h0, "driving with enable high")
      `CHK(word, 36'h3_8765_4321, "back-to-back read")
      desel();
      nx(1'h1, 1'h0);
      `CHK(dq_oe, 1'h0, "driving after deselect")
   endtask
   task automatic s_bytes();
      wr(3'h5, 6'h1F, 16'h0040, 36'h5_AAAA_AAAA);
      wr(3'h5, 6'h2A, 16'h0040, 36'hA_5555_5555);
      rdchk(16'h0040, 1'h1, 36'h0_AA55_AA55);
   endtask
   task automatic s_burst();
      logic [1:0] lo;
      wr(3'h5, 6'h1F, 16'h0020, 36'hA_5A5A_5A50);
      for (int k = 1; k < 4; k++) wr(3'h6, 6'h1F, ADDR_RST, 36'hA_5A5A_5A50 + 36'(k));
      for (int m = 0; m < 2; m++) begin
         // idle the pins first: a standing burst write would be sampled again and wrap onto the start word
         desel();
         burst_order_strap <= (m == 0);
         repeat (3) desel();
         rd(16'h0021, 1'h1);
         for (int i = 0; i < 5; i++) begin
            nx(i > 2, 1'h0);
            lo = burst_order_strap ? (2'h1 ^ 2'(i - 1)) : (2'h1 + 2'(i - 1));
            if (i > 0 && burst_order_strap)
               `CHK(word, 36'hA_5A5A_5A50 + {34'h0, lo}, "interleaved burst")
            else if (i > 0)
               `CHK(word, 36'hA_5A5A_5A50 + {34'h0, lo}, "linear burst")
         end
      end
   endtask
   task automatic s_refuse();
      wr(3'h5, 6'h1F, 16'h0030, 36'h1_0203_0405);
      i_host_model.drive(3'h1, 2'h1, 6'h1F, 1'h0, 16'h0030, 36'hE_EEEE_EEEE);
      nx(1'h1, 1'h0);
      nx(1'h1, 1'h0);
      // a stray write would land one edge after the start read, so look at the read after it
      nx(1'h1, 1'h0);
      `CHK(word, 36'h1_0203_0405, "strobe start wrote")
      i_host_model.drive(3'h3, 2'h3, 6'h3F, 1'h0, 16'h0040, WORD_RST);
      nx(1'h1, 1'h0);
      nx(1'h1, 1'h0);
      `CHK(dq_oe, 1'h1, "masked strobe deselected")
      `CHK(word, 36'h1_0203_0405, "masked strobe loaded address")
      rd(16'h0030, 1'h1);
      i_host_model.drive(3'h7, 2'h1, 6'h1F, 1'h0, ADDR_RST, 36'h7_7777_7777);
      nx(1'h1, 1'h0);
      `CHK(dq_oe, 1'h0, "driving in write cycle")
      rdchk(16'h0030, 1'h1, 36'h7_7777_7777);
   endtask

   // =====================================================
   // main sequence and verdict
   task automatic complete_run();
      if (num_errors == 0 && samples_checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   initial begin
      sys_rst = 1'h1;
      burst_order_strap = 1'h0;
      repeat (3) @(posedge clock);
      sys_rst <= 1'h0;
      repeat (4) @(posedge sram_clk);
      s_global();
      s_bytes();
      s_burst();
      s_refuse();
      repeat (20) @(posedge clock);
      `CHK(wr_events > 0, 1'h1, "no write events")
      `CHK(rd_events > 0, 1'h1, "no read events")
      complete_run();
   end
endmodule
